// [rtl/vps_delay_timer.sv]
// definite-time delay timer that turns a stage start into a trip
`default_nettype none
module vps_delay_timer #(
  parameter int DLY_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic ms_tick,
  input wire logic start,
  input wire logic start_only,
  input wire logic [DLY_W-1:0] delay_ms,
  // result
  output logic trip
);

  logic [DLY_W-1:0] cnt_reg, cnt_next;
  logic trip_reg, trip_next;

  // count whole ticks while started; fixed delay, not level dependent
  always_comb begin
    cnt_next = cnt_reg;
    if (!start) begin
      cnt_next = '0;
    end else if (ms_tick && cnt_reg < delay_ms) begin
      cnt_next = cnt_reg + 1'b1;
    end
    // trip holds while start holds and falls one cycle after it
    trip_next = start && !start_only && (cnt_reg >= delay_ms);
  end

  // register state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      trip_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      trip_reg <= trip_next;
    end
  end

  assign trip = trip_reg;

endmodule
`default_nettype wire

// [rtl/vps_voltage_protect.sv]
// three-stage voltage protection: phase over, phase under, residual over
`default_nettype none
module vps_voltage_protect
  import vps_pkg::*;
#(
  parameter int TICK_CYC = vps_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [vps_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [vps_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [vps_pkg::DATA_W-1:0] reg_rdata,
  // magnitudes from the measurement stage, 0.1 % units
  input wire logic [vps_pkg::VOLT_W-1:0] phase_voltage_a,
  input wire logic [vps_pkg::VOLT_W-1:0] phase_voltage_b,
  input wire logic [vps_pkg::VOLT_W-1:0] phase_voltage_c,
  input wire logic [vps_pkg::VOLT_W-1:0] residual_voltage,
  // overvoltage results
  output logic [2:0] ov_phase_start,
  output logic ov_start,
  output logic ov_trip,
  // undervoltage results
  output logic [2:0] uv_phase_start,
  output logic uv_start,
  output logic uv_trip,
  // residual overvoltage results
  output logic residual_overvoltage_stage_start,
  output logic residual_overvoltage_stage_trip
);

  import vps_pkg::*;

  localparam int PROD_W = 24;
  localparam int TICK_W = $clog2(TICK_CYC + 1);

  // ************************************************************
  // threshold helpers
  // ************************************************************

  // volts scaled by one hundred, so ratio limits need no divide
  function automatic logic [PROD_W-1:0] volt_x100(input logic [VOLT_W-1:0] v);
    volt_x100 = PROD_W'(v) * PROD_W'(PCT_FULL);
  endfunction

  // pick-up scaled to volt units times (100 + delta)
  function automatic logic [PROD_W-1:0] pick_x(input logic [7:0] pick,
                                               input logic [8:0] pct);
    pick_x = PROD_W'(pick) * PROD_W'(VOLT_SCALE) * PROD_W'(pct);
  endfunction

  // over-type start with hysteresis below pick-up
  function automatic logic over_hold(input logic [VOLT_W-1:0] v, input logic [7:0] pick,
                                     input logic [7:0] rr, input logic was);
    logic [8:0] drop_pct;
    drop_pct = (rr >= 8'(PCT_FULL)) ? 9'h000 : 9'(PCT_FULL) - {1'b0, rr};
    if (!was) begin
      over_hold = volt_x100(v) > pick_x(pick, 9'(PCT_FULL));
    end else begin
      over_hold = !(volt_x100(v) < pick_x(pick, drop_pct));
    end
  endfunction

  // under-type start with hysteresis above pick-up and a block floor
  function automatic logic under_hold(input logic [VOLT_W-1:0] v, input logic [7:0] pick,
                                      input logic [7:0] rr, input logic [7:0] blk,
                                      input logic was);
    logic above_blk;
    above_blk = volt_x100(v) > pick_x(blk, 9'(PCT_FULL));
    if (!was) begin
      under_hold = above_blk && (volt_x100(v) < pick_x(pick, 9'(PCT_FULL)));
    end else begin
      under_hold = above_blk &&
        !(volt_x100(v) > pick_x(pick, 9'(PCT_FULL) + {1'b0, rr}));
    end
  endfunction

  // ************************************************************
  // settings registers
  // ************************************************************
  logic [DATA_W-1:0] ov_ctrl_reg, ov_ctrl_next;
  logic [DATA_W-1:0] uv_ctrl_reg, uv_ctrl_next;
  logic [DATA_W-1:0] res_ctrl_reg, res_ctrl_next;
  logic [DLY_W-1:0] ov_dly_reg, ov_dly_next;
  logic [DLY_W-1:0] uv_dly_reg, uv_dly_next;
  logic [DLY_W-1:0] res_dly_reg, res_dly_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [DATA_W-1:0] status_word;

  // field views of the settings
  logic ov_en, ov_only, res_en, res_only, uv_only;
  logic [7:0] ov_pick, ov_rr, uv_pick, uv_rr, uv_blk, res_pick, res_rr;
  vps_uv_mode_t uv_mode;

  assign ov_en = ov_ctrl_reg[CTRL_EN_BIT];
  assign ov_only = ov_ctrl_reg[CTRL_ONLY_BIT];
  assign ov_pick = ov_ctrl_reg[CTRL_PICK_LSB +: 8];
  assign ov_rr = ov_ctrl_reg[CTRL_RR_LSB +: 8];
  assign uv_mode = vps_uv_mode_t'(uv_ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign uv_only = uv_ctrl_reg[CTRL_ONLY_BIT];
  assign uv_pick = uv_ctrl_reg[CTRL_PICK_LSB +: 8];
  assign uv_rr = uv_ctrl_reg[CTRL_RR_LSB +: 8];
  assign uv_blk = uv_ctrl_reg[CTRL_BLK_LSB +: 8];
  assign res_en = res_ctrl_reg[CTRL_EN_BIT];
  assign res_only = res_ctrl_reg[CTRL_ONLY_BIT];
  assign res_pick = res_ctrl_reg[CTRL_PICK_LSB +: 8];
  assign res_rr = res_ctrl_reg[CTRL_RR_LSB +: 8];

  // write decode and read mux; reads answer in the next cycle only
  always_comb begin
    ov_ctrl_next = ov_ctrl_reg;
    uv_ctrl_next = uv_ctrl_reg;
    res_ctrl_next = res_ctrl_reg;
    ov_dly_next = ov_dly_reg;
    uv_dly_next = uv_dly_reg;
    res_dly_next = res_dly_reg;
    rdata_next = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        OV_CTRL_ADDR: ov_ctrl_next = reg_wdata;
        OV_DELAY_ADDR: ov_dly_next = reg_wdata[DLY_W-1:0];
        UV_CTRL_ADDR: uv_ctrl_next = reg_wdata;
        UV_DELAY_ADDR: uv_dly_next = reg_wdata[DLY_W-1:0];
        RES_CTRL_ADDR: res_ctrl_next = reg_wdata;
        RES_DELAY_ADDR: res_dly_next = reg_wdata[DLY_W-1:0];
        default: ;  // status and unmapped writes are ignored
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OV_CTRL_ADDR: rdata_next = ov_ctrl_reg;
        OV_DELAY_ADDR: rdata_next = DATA_W'(ov_dly_reg);
        UV_CTRL_ADDR: rdata_next = uv_ctrl_reg;
        UV_DELAY_ADDR: rdata_next = DATA_W'(uv_dly_reg);
        RES_CTRL_ADDR: rdata_next = res_ctrl_reg;
        RES_DELAY_ADDR: rdata_next = DATA_W'(res_dly_reg);
        STATUS_ADDR: rdata_next = status_word;
        default: rdata_next = '0;
      endcase
    end
  end

  // settings flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ov_ctrl_reg <= OV_CTRL_RST;
      uv_ctrl_reg <= UV_CTRL_RST;
      res_ctrl_reg <= RES_CTRL_RST;
      ov_dly_reg <= DLY_RST;
      uv_dly_reg <= DLY_RST;
      res_dly_reg <= DLY_RST;
      rdata_reg <= '0;
    end else begin
      ov_ctrl_reg <= ov_ctrl_next;
      uv_ctrl_reg <= uv_ctrl_next;
      res_ctrl_reg <= res_ctrl_next;
      ov_dly_reg <= ov_dly_next;
      uv_dly_reg <= uv_dly_next;
      res_dly_reg <= res_dly_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ************************************************************
  // millisecond tick divider
  // ************************************************************
  logic [TICK_W-1:0] div_reg, div_next;
  logic tick_reg, tick_next;

  // one-cycle enable every TICK_CYC clocks
  always_comb begin
    tick_next = (div_reg == TICK_W'(TICK_CYC - 1));
    div_next = tick_next ? '0 : div_reg + 1'b1;
  end

  // divider flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  // ************************************************************
  // start detection
  // ************************************************************
  logic [VOLT_W-1:0] ph_volt [3];
  logic [2:0] ov_ph_reg, ov_ph_next, uv_ph_reg, uv_ph_next;
  logic ov_gen_reg, ov_gen_next, uv_gen_reg, uv_gen_next;
  logic res_gen_reg, res_gen_next;
  logic [1:0] uv_count;
  logic [1:0] uv_need;

  assign ph_volt[0] = phase_voltage_a;
  assign ph_volt[1] = phase_voltage_b;
  assign ph_volt[2] = phase_voltage_c;

  // per-phase flags, then general starts; a disabled stage stays quiet
  always_comb begin
    ov_ph_next = '0;
    uv_ph_next = '0;
    uv_count = '0;
    for (int i = 0; i < 3; i++) begin
      if (ov_en) begin
        ov_ph_next[i] = over_hold(ph_volt[i], ov_pick, ov_rr, ov_ph_reg[i]);
      end
      if (uv_mode != VPS_UV_OFF) begin
        uv_ph_next[i] = under_hold(ph_volt[i], uv_pick, uv_rr, uv_blk, uv_ph_reg[i]);
      end
      uv_count = uv_count + 2'(uv_ph_next[i]);
    end
    ov_gen_next = |ov_ph_next;
    unique case (uv_mode)
      VPS_UV_OFF: uv_need = 2'h0;
      VPS_UV_ONE: uv_need = 2'h1;
      VPS_UV_TWO: uv_need = 2'h2;
      VPS_UV_ALL: uv_need = 2'h3;
    endcase
    // enough phases under before the stage operates
    uv_gen_next = (uv_mode != VPS_UV_OFF) && (uv_count >= uv_need);
    // the residual input already carries the 3U0 scaling
    res_gen_next = res_en &&
      over_hold(residual_voltage, res_pick, res_rr, res_gen_reg);
  end

  // start flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ov_ph_reg <= '0;
      uv_ph_reg <= '0;
      ov_gen_reg <= 1'b0;
      uv_gen_reg <= 1'b0;
      res_gen_reg <= 1'b0;
    end else begin
      ov_ph_reg <= ov_ph_next;
      uv_ph_reg <= uv_ph_next;
      ov_gen_reg <= ov_gen_next;
      uv_gen_reg <= uv_gen_next;
      res_gen_reg <= res_gen_next;
    end
  end

  assign ov_phase_start = ov_ph_reg;
  assign ov_start = ov_gen_reg;
  assign uv_phase_start = uv_ph_reg;
  assign uv_start = uv_gen_reg;
  assign residual_overvoltage_stage_start = res_gen_reg;

  // ************************************************************
  // delay timers
  // ************************************************************
  logic ov_trip_w, uv_trip_w, res_trip_w;

  vps_delay_timer #(.DLY_W(DLY_W)) u_ov_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .ms_tick(tick_reg),
    .start(ov_gen_reg),
    .start_only(ov_only),
    .delay_ms(ov_dly_reg),
    .trip(ov_trip_w)
  );

  vps_delay_timer #(.DLY_W(DLY_W)) u_uv_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .ms_tick(tick_reg),
    .start(uv_gen_reg),
    .start_only(uv_only),
    .delay_ms(uv_dly_reg),
    .trip(uv_trip_w)
  );

  vps_delay_timer #(.DLY_W(DLY_W)) u_res_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .ms_tick(tick_reg),
    .start(res_gen_reg),
    .start_only(res_only),
    .delay_ms(res_dly_reg),
    .trip(res_trip_w)
  );

  assign ov_trip = ov_trip_w;
  assign uv_trip = uv_trip_w;
  assign residual_overvoltage_stage_trip = res_trip_w;

  // status view of the live flags
  always_comb begin
    status_word = '0;
    status_word[ST_OV_PH_LSB +: 3] = ov_ph_reg;
    status_word[ST_OV_GEN_BIT] = ov_gen_reg;
    status_word[ST_UV_PH_LSB +: 3] = uv_ph_reg;
    status_word[ST_UV_GEN_BIT] = uv_gen_reg;
    status_word[ST_RES_GEN_BIT] = res_gen_reg;
    status_word[ST_OV_TRIP_BIT] = ov_trip_w;
    status_word[ST_UV_TRIP_BIT] = uv_trip_w;
    status_word[ST_RES_TRIP_BIT] = res_trip_w;
  end

endmodule
`default_nettype wire

// [shared/vps_pkg.sv]
// shared constants for the voltage protection stages block
`default_nettype none
package vps_pkg;

  // ************************************************************
  // widths and timing
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int VOLT_W = 12;             // magnitude in 0.1 % of nominal
  localparam int DLY_W = 16;              // delay in ms, up to 60 000
  localparam int CLK_PERIOD_PS = 5000;    // 200 MHz reference clock
  localparam int TICK_PERIOD_PS = 1000000000;  // one millisecond
  localparam int TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int VOLT_SCALE = 10;         // volt units per percent
  localparam int PCT_FULL = 100;

  // ************************************************************
  // register indices (word addresses)
  // ************************************************************
  localparam logic [ADDR_W-1:0] OV_CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] OV_DELAY_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] UV_CTRL_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] UV_DELAY_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] RES_CTRL_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] RES_DELAY_ADDR = 4'h5;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h6;

  // ************************************************************
  // control field positions
  // ************************************************************
  localparam int CTRL_EN_BIT = 0;         // on/off for over and residual
  localparam int CTRL_MODE_LSB = 0;       // undervoltage mode, two bits
  localparam int CTRL_ONLY_BIT = 2;       // start signal only
  localparam int CTRL_PICK_LSB = 8;       // pick-up in percent
  localparam int CTRL_RR_LSB = 16;        // reset ratio in percent
  localparam int CTRL_BLK_LSB = 24;       // undervoltage block level in percent

  // ************************************************************
  // status field positions
  // ************************************************************
  localparam int ST_OV_PH_LSB = 0;
  localparam int ST_OV_GEN_BIT = 3;
  localparam int ST_UV_PH_LSB = 4;
  localparam int ST_UV_GEN_BIT = 7;
  localparam int ST_RES_GEN_BIT = 8;
  localparam int ST_OV_TRIP_BIT = 12;
  localparam int ST_UV_TRIP_BIT = 13;
  localparam int ST_RES_TRIP_BIT = 14;

  // undervoltage operating modes
  typedef enum logic [1:0] {
    VPS_UV_OFF = 2'b00,
    VPS_UV_ONE = 2'b01,
    VPS_UV_TWO = 2'b10,
    VPS_UV_ALL = 2'b11
  } vps_uv_mode_t;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] OV_PICK_RST = 8'h3f;    // 63 %
  localparam logic [7:0] UV_PICK_RST = 8'h5a;    // 90 %
  localparam logic [7:0] RES_PICK_RST = 8'h1e;   // 30 %
  localparam logic [7:0] UV_BLK_RST = 8'h0a;     // 10 %
  localparam logic [7:0] RR_RST = 8'h05;         // 5 %
  localparam logic [DLY_W-1:0] DLY_RST = 16'h0064;  // 100 ms
  localparam logic [DATA_W-1:0] OV_CTRL_RST =
    {8'h00, RR_RST, OV_PICK_RST, 8'h01};
  localparam logic [DATA_W-1:0] UV_CTRL_RST =
    {UV_BLK_RST, RR_RST, UV_PICK_RST, 8'h01};
  localparam logic [DATA_W-1:0] RES_CTRL_RST =
    {8'h00, RR_RST, RES_PICK_RST, 8'h01};

endpackage
`default_nettype wire

// [tb/vps_meas_model.sv]
// measurement stage stand-in that feeds voltage magnitudes
`default_nettype none
module vps_meas_model
  import vps_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // magnitudes, 0.1 % units
  output logic [vps_pkg::VOLT_W-1:0] phase_voltage_a,
  output logic [vps_pkg::VOLT_W-1:0] phase_voltage_b,
  output logic [vps_pkg::VOLT_W-1:0] phase_voltage_c,
  output logic [vps_pkg::VOLT_W-1:0] residual_voltage
);
  timeunit 1ns;
  timeprecision 1ps;

  // healthy nominal system at power-up
  initial begin
    phase_voltage_a = 12'h3e8;
    phase_voltage_b = 12'h3e8;
    phase_voltage_c = 12'h3e8;
    residual_voltage = 12'h000;
  end

  // new magnitudes land together just after an edge, as a real
  // filter output would, so no phase leads the others by a cycle
  task automatic set_v(input logic [VOLT_W-1:0] a, b, c, r);
    @(posedge ref_clk);
    phase_voltage_a <= a;
    phase_voltage_b <= b;
    phase_voltage_c <= c;
    residual_voltage <= r;
  endtask
endmodule
`default_nettype wire

// [tb/vps_voltage_protect_assertions.sv]
// port-level checker for the voltage protection stages block
`default_nettype none
module vps_voltage_protect_assertions
  import vps_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [vps_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [vps_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [vps_pkg::DATA_W-1:0] reg_rdata,
  // magnitudes
  input wire logic [vps_pkg::VOLT_W-1:0] phase_voltage_a,
  input wire logic [vps_pkg::VOLT_W-1:0] phase_voltage_b,
  input wire logic [vps_pkg::VOLT_W-1:0] phase_voltage_c,
  input wire logic [vps_pkg::VOLT_W-1:0] residual_voltage,
  // stage results
  input wire logic [2:0] ov_phase_start,
  input wire logic ov_start,
  input wire logic ov_trip,
  input wire logic [2:0] uv_phase_start,
  input wire logic uv_start,
  input wire logic uv_trip,
  input wire logic residual_overvoltage_stage_start,
  input wire logic residual_overvoltage_stage_trip
);
  import vps_pkg::*;

  // ************************************************************
  // checks, all in the one clock domain
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // a phase flag must pull the general start up within a cycle
  chk_ov_gen_follows: assert property ($rose(|ov_phase_start) |-> ##[0:1] ov_start)
    else $error("over general start missing after phase start");
  // general under start needs a phase flag now or just before
  chk_uv_gen_phase: assert property (uv_start |-> (|uv_phase_start) || (|$past(uv_phase_start)))
    else $error("under general start without phase flag");
  // a dead phase a is treated as open breaker, never as undervoltage; a residual start needs residual voltage
  chk_uv_block_low: assert property (uv_phase_start[0] |-> $past(phase_voltage_a) != 12'h000)
    else $error("under start on a zero voltage");
  chk_res_needs_volt: assert property ($rose(residual_overvoltage_stage_start) |-> $past(residual_voltage) != 12'h000)
    else $error("residual start with no residual voltage");
  // trips only ever follow a start of the same stage
  chk_ov_trip_start: assert property (ov_trip |-> $past(ov_start))
    else $error("over trip without start");
  chk_uv_trip_start: assert property (uv_trip |-> $past(uv_start))
    else $error("under trip without start");
  chk_res_trip_start: assert property (residual_overvoltage_stage_trip |-> $past(residual_overvoltage_stage_start))
    else $error("residual trip without start");
  // once tripped, the trip holds while the start holds, and drops after it
  chk_trip_holds: assert property (ov_trip && ov_start |=> ov_trip)
    else $error("over trip dropped while start held");
  chk_trip_clears: assert property ($fell(uv_start) |=> !uv_trip)
    else $error("under trip outlived its start");

  // main scenarios reached
  cover property ($rose(ov_trip));
  cover property ($rose(uv_trip));
  cover property ($rose(residual_overvoltage_stage_trip));
endmodule

bind vps_voltage_protect vps_voltage_protect_assertions chk_i (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .phase_voltage_a(phase_voltage_a), .phase_voltage_b(phase_voltage_b),
  .phase_voltage_c(phase_voltage_c), .residual_voltage(residual_voltage),
  .ov_phase_start(ov_phase_start), .ov_start(ov_start), .ov_trip(ov_trip),
  .uv_phase_start(uv_phase_start), .uv_start(uv_start), .uv_trip(uv_trip),
  .residual_overvoltage_stage_start(residual_overvoltage_stage_start),
  .residual_overvoltage_stage_trip(residual_overvoltage_stage_trip)
);
`default_nettype wire

// [tb/vps_voltage_protect_bench.sv]
// self-checking bench for the voltage protection stages block
`default_nettype none
module vps_voltage_protect_bench
  import vps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, rst, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [VOLT_W-1:0] va, vb, vc, vr;
  logic [2:0] ov_ph, uv_ph;
  logic ov_st, ov_tr, uv_st, uv_tr, res_st, res_tr;
  int err_count = 0;
  int check_count = 0;

  // ************************************************************
  // clock, partner and design
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  vps_meas_model meas (.ref_clk(ref_clk), .phase_voltage_a(va), .phase_voltage_b(vb),
    .phase_voltage_c(vc), .residual_voltage(vr));

  // short millisecond tick keeps delay tests to tens of cycles
  vps_voltage_protect #(.TICK_CYC(10)) dut (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .phase_voltage_a(va), .phase_voltage_b(vb),
    .phase_voltage_c(vc), .residual_voltage(vr), .ov_phase_start(ov_ph),
    .ov_start(ov_st), .ov_trip(ov_tr), .uv_phase_start(uv_ph), .uv_start(uv_st),
    .uv_trip(uv_tr), .residual_overvoltage_stage_start(res_st),
    .residual_overvoltage_stage_trip(res_tr));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // wait, then step past the edge so registered outputs have settled
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  function automatic logic trip_of(int s);
    return s == 0 ? ov_tr : (s == 1 ? uv_tr : res_tr);
  endfunction

  // cycles until a stage trips, bounded so a dead timer cannot hang
  task automatic trip_time(int s, output int n);
    n = 0;
    #1;  // step off the edge that launched the stimulus
    while (trip_of(s) !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    logic [DATA_W-1:0] d;
    rd(OV_CTRL_ADDR, d);
    chk(d, 32'h00053f01);
    rd(UV_CTRL_ADDR, d);
    chk(d, 32'h0a055a01);
    rd(RES_CTRL_ADDR, d);
    chk(d, 32'h00051e01);
    for (int i = 1; i < 6; i += 2) begin
      rd(i[3:0], d);
      chk(d, 32'h00000064);
    end
    // read data stand for one cycle only, then the port returns to zero
    cyc(1);
    chk(reg_rdata, 32'h00000000);
    rd(4'h9, d);
    chk(d, 32'h00000000);
    // nominal voltage already lies above the 63 % default pick-up
    chk({ov_ph, ov_st}, 4'b1111);
  endtask

  task automatic t_ov();
    int n;
    logic [DATA_W-1:0] d;
    wr(OV_CTRL_ADDR, 32'h00056e01);
    wr(OV_DELAY_ADDR, 32'h00000003);
    meas.set_v(12'h3e8, 12'h44c, 12'h3e8, 12'h000);
    cyc(3);
    chk(ov_st, 1'b0);
    meas.set_v(12'h3e8, 12'h44d, 12'h3e8, 12'h000);
    trip_time(0, n);
    chk(ov_ph, 3'b010);
    chk(ov_st, 1'b1);
    chk(n > 18 && n <= 40, 1'b1);
    // status mirrors phase b start, over general start and over trip
    rd(STATUS_ADDR, d);
    chk(d, 32'h0000100a);
    // 104.6 % still inside the 5 % band below 110 %
    meas.set_v(12'h3e8, 12'h416, 12'h3e8, 12'h000);
    cyc(3);
    chk({ov_st, ov_tr}, 2'b11);
    meas.set_v(12'h3e8, 12'h414, 12'h3e8, 12'h000);
    cyc(3);
    chk({ov_st, ov_tr}, 2'b00);
  endtask

  task automatic t_clear();
    wr(OV_DELAY_ADDR, 32'h00000005);
    meas.set_v(12'h3e8, 12'h44d, 12'h3e8, 12'h000);
    cyc(25);
    meas.set_v(12'h3e8, 12'h3e8, 12'h3e8, 12'h000);
    cyc(5);
    meas.set_v(12'h3e8, 12'h44d, 12'h3e8, 12'h000);
    cyc(35);
    chk(ov_tr, 1'b0);
    meas.set_v(12'h3e8, 12'h3e8, 12'h3e8, 12'h000);
    cyc(3);
    // a switched-off stage ignores an overvoltage entirely
    wr(OV_CTRL_ADDR, 32'h00056e00);
    meas.set_v(12'h3e8, 12'h44d, 12'h3e8, 12'h000);
    cyc(3);
    chk({ov_ph, ov_st, ov_tr}, 5'b00000);
  endtask

  task automatic t_uv();
    for (int m = 0; m < 4; m++) begin
      wr(UV_CTRL_ADDR, {24'h0a055a, 6'h00, m[1:0]});
      meas.set_v(12'h352, 12'h352, 12'h3e8, 12'h000);
      cyc(3);
      chk(uv_ph, m == 0 ? 3'b000 : 3'b011);
      chk(uv_st, m != 0 && m <= 2);
    end
    wr(UV_CTRL_ADDR, 32'h0a055a01);
    wr(UV_DELAY_ADDR, 32'h00000000);
    meas.set_v(12'h064, 12'h3e8, 12'h3e8, 12'h000);
    cyc(3);
    chk({uv_ph, uv_st}, 4'b0000);
    meas.set_v(12'h065, 12'h3e8, 12'h3e8, 12'h000);
    cyc(4);
    chk({uv_ph, uv_st, uv_tr}, 5'b00111);
    meas.set_v(12'h3e8, 12'h3e8, 12'h3e8, 12'h000);
    cyc(3);
    chk({uv_st, uv_tr}, 2'b00);
  endtask

  task automatic t_res();
    int n;
    wr(RES_DELAY_ADDR, 32'h00000003);
    meas.set_v(12'h3e8, 12'h3e8, 12'h3e8, 12'h12c);
    cyc(3);
    chk(res_st, 1'b0);
    // a small and a large excess must trip after the same delay
    for (int i = 0; i < 2; i++) begin
      meas.set_v(12'h3e8, 12'h3e8, 12'h3e8, i ? 12'h384 : 12'h12d);
      trip_time(2, n);
      chk(res_st, 1'b1);
      chk(n > 18 && n <= 40, 1'b1);
      meas.set_v(12'h3e8, 12'h3e8, 12'h3e8, 12'h000);
      cyc(3);
    end
    wr(RES_CTRL_ADDR, 32'h00051e05);
    meas.set_v(12'h3e8, 12'h3e8, 12'h3e8, 12'h1f4);
    cyc(50);
    chk({res_st, res_tr}, 2'b10);
    wr(RES_CTRL_ADDR, 32'h00051e00);
    cyc(3);
    chk({res_st, res_tr}, 2'b00);
  endtask

  // ************************************************************
  // sequence, watchdog and verdict
  // ************************************************************
  task automatic end_of_test();
    $display("checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence; the first request waits for the edge after release
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h00000000;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_ov();
    t_clear();
    t_uv();
    t_res();
    end_of_test();
  end

  // the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
